/* File: inc/frs_consts.svh */
// Timing, threshold and reset constants for the fault and restart supervisor.
// Assumes a single 25 MHz clock; all long times are counted in 1 ms ticks.
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH

`define CLK_HZ 25000000
`define TICK_TIME_US 1000
`define RESTART_DELAY_S 1
`define OV_WINDOW_S 60
`define ADDR_SETTLE_S 15
`define SERVICE_PHASE_MS 500
`define OV_RETRY_LIMIT 2'h3
`define FAN_SPREAD_PCT 20
`define ADDR_DEFAULT_LOW 4'h0
`define STATUS_RESET 8'h00
`define ALARM_RESET 10'h000

`endif

/* File: inc/frs_pkg.sv */
// Types shared by the fault and restart supervisor and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package frs_pkg;

  // Supervisor states, one-hot.
  typedef enum logic [5:0] {
    ST_OFF      = 6'b000001,
    ST_PRECHECK = 6'b000010,
    ST_WAIT_CMD = 6'b000100,
    ST_ON       = 6'b001000,
    ST_RETRY    = 6'b010000,
    ST_LATCHED  = 6'b100000
  } sup_state_t;

  // One bit per shutdown cause; also used for the latch-off selection.
  typedef struct packed {
    logic ov;
    logic oc;
    logic ot;
  } shut_t;

  typedef struct packed {
    logic restart_ok;
    logic latched_off;
    logic waiting_cmd;
    logic output_on;
    logic ext_fault;
    shut_t fault;
  } status_t;

  // Info bit 0 is the overtemp_warning alarm.
  typedef struct packed {
    logic fan_wear;
    logic [8:0] info;
  } alarm_t;

  typedef struct packed {
    logic input_good_lamp;
    logic output_good_lamp;
    logic fault_lamp;
    logic service_lamp;
  } lamps_t;

endpackage : frs_pkg

/* File: rtl/fan_spread_check.sv */
// Flags a spread between two fan speed readings above the wear threshold.
// Assumes both readings are unsigned and synchronous to the clock.
`timescale 1ns/1ps
`include "frs_consts.svh"
module fan_spread_check (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [7:0] fan_a, // First fan speed.
  input wire logic [7:0] fan_b, // Second fan speed.
  output logic wear // High while speeds differ too much.
);
  logic [7:0] diff;
  logic [7:0] top;
  logic [15:0] lhs;
  logic [15:0] rhs;

  // Percent compare without a divider: diff*100 against pct*larger speed.
  always_comb begin
    top = (fan_a > fan_b) ? fan_a : fan_b;
    diff = (fan_a > fan_b) ? fan_a - fan_b : fan_b - fan_a;
    lhs = 16'(diff) * 16'h0064;
    rhs = 16'(top) * 16'(`FAN_SPREAD_PCT);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wear <= 1'b0;
    end else begin
      wear <= lhs > rhs;
    end
  end
endmodule : fan_spread_check

/* File: rtl/fault_restart_supervisor.sv */
// Fault-management and restart supervisor of a rack power supply.
// Assumes all inputs synchronous to clk; faults arrive as live levels from
// the protection logic and the management controller drives the strobes.
`timescale 1ns/1ps
`include "frs_consts.svh"

// What this block does
// - Per-cause latch-off selection for OV, OT, OC.
// - Successful restart clears alarms, sets restart flag.
// - OC and OT auto-restart unless configured latch.
// - OV retries three times, 1 s apart, then latches.
// - Under four OV shutdowns per minute resets count.
// - Alert only in final state; contents keep updating.
// - Fault bits sticky; operational bits track live.
// - External faults never light fault lamp or pin.
// - Input lamp blinks out of range, off absent.
// - Power-up alert unless back-biased; insertion always alerts.
// - Status changes alert; clear-faults itself does not.
// - Default address low bits zero for 15 s.
// - Matching bus voltage lets output turn on.
// - Mismatched bus voltage waits for commanded voltage.
// - Bus under 40 V turns on directly.
// - Information alarms flagged without any shutdown.
// - Fan spread over 20 percent flags wear.
// - Output lamp steady, blinking in limit or overload, else off.
// - Fault lamp steady on shutdown, blinks overtemp warning in bus mode.
// - Service lamp flashes half second on and off.
module fault_restart_supervisor #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ / 1000000 * `TICK_TIME_US,
  parameter int unsigned RESTART_MS = `RESTART_DELAY_S * 1000,
  parameter int unsigned WINDOW_MS = `OV_WINDOW_S * 1000,
  parameter int unsigned ADDR_MS = `ADDR_SETTLE_S * 1000,
  parameter int unsigned BLINK_MS = `SERVICE_PHASE_MS
) (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic enable_pin, // Remote on/off pin, high for on.
  input wire logic op_on, // Operation command output on.
  input wire logic vout_cmd_strobe, // Controller commanded an output voltage.
  input wire frs_pkg::shut_t fault_live, // Live internal shutdown causes.
  input wire frs_pkg::shut_t latch_cfg, // Fault response: 1 latches off.
  input wire logic ext_overload, // External overload present.
  input wire logic input_out_of_range, // Input out of range, power left.
  input wire logic input_absent, // Input completely gone.
  input wire logic back_biased, // Held up through bias or standby rail.
  input wire logic hot_insert, // Pulse on insertion into a live system.
  input wire logic bus_v_match, // Bus voltage equals commanded setpoint.
  input wire logic bus_v_below_40, // Bus voltage below 40 V.
  input wire logic output_present, // Main output voltage present.
  input wire logic power_limit, // Unit in power or current limit.
  input wire logic bus_iface_mode, // Management bus mode selected.
  input wire logic [8:0] info_alarm, // Information-only alarm conditions.
  input wire logic [7:0] fan_speed_a, // First fan speed.
  input wire logic [7:0] fan_speed_b, // Second fan speed.
  input wire logic [6:0] addr_sensed, // Address derived from backplane.
  input wire logic service_req, // Service lamp requested.
  input wire logic clear_faults, // Clear-faults command pulse.
  output logic main_on, // Main output enable.
  output frs_pkg::status_t status, // Status register contents.
  output frs_pkg::alarm_t alarm, // Alarm register contents.
  output logic smbalert_n, // Bus alert, active low.
  output logic fault_pin, // Fault output pin, high on fault.
  output frs_pkg::lamps_t lamps, // Front-panel lamp drives.
  output logic [6:0] bus_addr, // Address the unit answers at.
  output logic addr_ready // Address derivation finished.
);
  import frs_pkg::*;

  sup_state_t state, next_state;
  shut_t latch_cause;
  logic tick, fan_wear, any_off, go_latch, restart_ev, ov_shut, delay_done, ov_limit;
  logic blink, clr_d, pending, boot_done, change;
  logic [1:0] ov_count;
  logic [16:0] delay_cnt, window_cnt, addr_cnt, blink_cnt;
  logic [17:0] snap, prev_snap;

  // States in which a pending alert may be announced; the registers keep updating in every state.
  function automatic logic is_final(input sup_state_t s);
    is_final = (s != ST_RETRY) && (s != ST_PRECHECK);
  endfunction : is_final

  tick_divider #(.DIV(TICK_CYCLES)) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  fan_spread_check u_fan (
    .clk(clk),
    .reset_n(reset_n),
    .fan_a(fan_speed_a),
    .fan_b(fan_speed_b),
    .wear(fan_wear)
  );

  // Off requests. The two-second hold that clears a latch is the controller's job.
  assign any_off = !enable_pin || !op_on || input_absent;
  assign ov_shut = (state == ST_ON) && fault_live.ov && !any_off;
  assign delay_done = delay_cnt == 17'(RESTART_MS);
  assign go_latch = (|(fault_live & latch_cfg)) || (fault_live.ov && ov_count == `OV_RETRY_LIMIT);
  assign restart_ev = (state == ST_RETRY) && (next_state == ST_ON);

  // Next-state decision; any off request wins and also drops a latch.
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (!any_off) next_state = ST_PRECHECK;
      end
      ST_PRECHECK: begin
        if (bus_v_below_40 || bus_v_match) next_state = ST_ON;
        else next_state = ST_WAIT_CMD;
      end
      ST_WAIT_CMD: begin
        if (vout_cmd_strobe) next_state = ST_ON;
      end
      ST_ON: begin
        if (|fault_live) next_state = go_latch ? ST_LATCHED : ST_RETRY;
      end
      ST_RETRY: begin
        if (delay_done && !(|fault_live)) next_state = ST_ON;
      end
      ST_LATCHED: begin
        // Switching a cause back to restart releases without any hold.
        if (!ov_limit && !(|(latch_cause & latch_cfg))) next_state = ST_RETRY;
      end
      default: next_state = ST_OFF;
    endcase
    if (any_off) next_state = ST_OFF;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state <= ST_OFF;
    else state <= next_state;
  end

  // Restart delay counter, only alive in the retry state.
  always_ff @(posedge clk) begin
    if (!reset_n || state != ST_RETRY) delay_cnt <= 17'h0;
    else if (tick && !delay_done) delay_cnt <= delay_cnt + 17'h1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n || state == ST_OFF) begin
      ov_count <= 2'h0;
      window_cnt <= 17'h0;
    end else if (ov_shut) begin
      if (ov_count == 2'h0) window_cnt <= 17'h0;
      if (ov_count != `OV_RETRY_LIMIT) ov_count <= ov_count + 2'h1;
    end else if (ov_count != 2'h0 && tick) begin
      if (window_cnt == 17'(WINDOW_MS - 1)) begin
        ov_count <= 2'h0;
        window_cnt <= 17'h0;
      end else begin
        window_cnt <= window_cnt + 17'h1;
      end
    end
  end

  // Latch causes; the over-voltage count latch only drops with an off request.
  always_ff @(posedge clk) begin
    if (!reset_n || state == ST_OFF) begin
      ov_limit <= 1'b0;
      latch_cause <= '0;
    end else begin
      if (ov_shut && ov_count == `OV_RETRY_LIMIT) ov_limit <= 1'b1;
      if (state == ST_ON && next_state == ST_LATCHED) latch_cause <= fault_live & latch_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= `STATUS_RESET;
    end else begin
      status.fault <= (clear_faults ? 3'h0 : status.fault) | fault_live;
      status.restart_ok <= restart_ev | (status.restart_ok & !clear_faults);
      status.latched_off <= next_state == ST_LATCHED;
      status.waiting_cmd <= next_state == ST_WAIT_CMD;
      status.output_on <= next_state == ST_ON;
      status.ext_fault <= ext_overload | input_out_of_range;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm <= `ALARM_RESET;
    end else if (restart_ev) begin
      alarm <= {fan_wear, info_alarm};
    end else begin
      alarm <= (clear_faults ? `ALARM_RESET : alarm) | {fan_wear, info_alarm};
    end
  end

  // Changes caused by a clear are filtered by the delayed clear flag.
  assign snap = {status, alarm};
  assign change = (snap != prev_snap) && !clr_d;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_snap <= 18'h0;
      clr_d <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      prev_snap <= snap;
      clr_d <= clear_faults;
      boot_done <= 1'b1;
    end
  end

  // alert source; a new event wins over a clear.
  always_ff @(posedge clk) begin
    if (!reset_n) pending <= 1'b0;
    else pending <= (pending & !clear_faults) | change | hot_insert
                    | (!boot_done && !back_biased);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) smbalert_n <= 1'b1;
    else smbalert_n <= !(pending && is_final(state));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_on <= 1'b0;
      fault_pin <= 1'b0;
    end else begin
      main_on <= next_state == ST_ON;
      fault_pin <= (next_state == ST_RETRY) || (next_state == ST_LATCHED);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      blink_cnt <= 17'h0;
      blink <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == 17'(BLINK_MS - 1)) begin
        blink_cnt <= 17'h0;
        blink <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 17'h1;
      end
    end
  end

  // Lamp patterns; all share one blink phase so they flash together.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lamps <= '0;
    end else begin
      lamps.input_good_lamp <= !input_absent && (!input_out_of_range || blink);
      lamps.output_good_lamp <= output_present && main_on
                                && (!(power_limit || ext_overload) || blink);
      lamps.fault_lamp <= ((next_state == ST_RETRY) || (next_state == ST_LATCHED))
                          || (bus_iface_mode && info_alarm[0] && blink);
      lamps.service_lamp <= service_req && blink;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || hot_insert) begin
      addr_cnt <= 17'h0;
      addr_ready <= 1'b0;
      bus_addr <= 7'h0;
    end else begin
      if (tick && !addr_ready) addr_cnt <= addr_cnt + 17'h1;
      addr_ready <= addr_cnt >= 17'(ADDR_MS);
      bus_addr <= addr_ready ? addr_sensed : {addr_sensed[6:4], `ADDR_DEFAULT_LOW};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ov_at_limit;
    state == ST_ON && fault_live.ov && ov_count == 2'h3 && !any_off;
  endsequence
  sequence s_window_end;
    ov_count != 2'h0 && tick && window_cnt == 17'(WINDOW_MS - 1) && !ov_shut;
  endsequence

  a_latch_select: assert property (
    (state == ST_ON && fault_live.oc && latch_cfg.oc && !any_off) |=> state == ST_LATCHED)
    else $error("Configured over-current latch did not latch off.");
  a_restart_flag: assert property (
    restart_ev |=> status.restart_ok && status.output_on)
    else $error("Restart did not set the restart flag.");
  a_auto_restart: assert property (
    (state == ST_ON && fault_live.ot && !fault_live.ov && !latch_cfg.ot && !latch_cfg.oc
     && !any_off) |=> state == ST_RETRY && fault_pin)
    else $error("Over-temperature did not enter auto-restart.");
  a_ov_limit: assert property (
    s_ov_at_limit |=> state == ST_LATCHED && ov_limit)
    else $error("Fourth over-voltage shutdown did not latch.");
  a_window_reset: assert property (
    s_window_end |=> ov_count == 2'h0 && window_cnt == 17'h0)
    else $error("Over-voltage window did not restart.");
  a_alert_final: assert property (
    $fell(smbalert_n) |-> is_final($past(state)) && $past(pending))
    else $error("Alert raised in a transitional state.");
  a_fault_sticky: assert property (
    (status.fault.ov && !clear_faults) |=> status.fault.ov)
    else $error("Fault bit dropped without a clear.");
  a_input_lamp: assert property (
    input_absent |=> !lamps.input_good_lamp)
    else $error("Input lamp lit with input absent.");
  a_precheck_wait: assert property (
    (state == ST_PRECHECK && !bus_v_match && !bus_v_below_40 && !any_off)
    |=> state == ST_WAIT_CMD && !main_on)
    else $error("Mismatched bus voltage did not wait for command.");
  a_addr_default: assert property (
    !addr_ready |=> bus_addr[3:0] == 4'h0)
    else $error("Address low bits not zero before settling.");
endmodule : fault_restart_supervisor

/* File: rtl/tick_divider.sv */
// Divides the system clock into a one-cycle enable pulse.
// Assumes a free-running clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV = 25000
) (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  output logic tick // One-cycle pulse every DIV cycles.
);
  logic [31:0] count;

  // Counter wraps at DIV and fires the pulse on the wrap.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count == DIV - 1) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : tick_divider

/* File: verification/fault_restart_supervisor_test.sv */
// Self-checking bench for the fault and restart supervisor with shortened timers.
// Assumes the controller model drives the command side; the bench drives all live levels.
`timescale 1ns/1ps
module fault_restart_supervisor_test;
  import frs_pkg::*;
  logic clk, reset_n, enable_pin, op_on, vout_cmd_strobe, clear_faults;
  logic ext_overload, input_out_of_range, input_absent, back_biased, hot_insert;
  logic bus_v_match, bus_v_below_40, output_present, power_limit, bus_iface_mode;
  logic service_req, main_on, smbalert_n, fault_pin, addr_ready;
  logic [8:0] info_alarm;
  logic [7:0] fan_speed_a, fan_speed_b;
  logic [6:0] addr_sensed, bus_addr;
  shut_t fault_live, latch_cfg;
  status_t status;
  alarm_t alarm;
  lamps_t lamps;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  fault_restart_supervisor #(.TICK_CYCLES(4), .RESTART_MS(3), .WINDOW_MS(40), .ADDR_MS(5),
    .BLINK_MS(2)) u_fault_restart_supervisor (.clk(clk), .reset_n(reset_n),
    .enable_pin(enable_pin), .op_on(op_on), .vout_cmd_strobe(vout_cmd_strobe),
    .fault_live(fault_live), .latch_cfg(latch_cfg), .ext_overload(ext_overload),
    .input_out_of_range(input_out_of_range), .input_absent(input_absent),
    .back_biased(back_biased), .hot_insert(hot_insert), .bus_v_match(bus_v_match),
    .bus_v_below_40(bus_v_below_40), .output_present(output_present),
    .power_limit(power_limit), .bus_iface_mode(bus_iface_mode), .info_alarm(info_alarm),
    .fan_speed_a(fan_speed_a), .fan_speed_b(fan_speed_b), .addr_sensed(addr_sensed),
    .service_req(service_req), .clear_faults(clear_faults), .main_on(main_on),
    .status(status), .alarm(alarm), .smbalert_n(smbalert_n), .fault_pin(fault_pin),
    .lamps(lamps), .bus_addr(bus_addr), .addr_ready(addr_ready));

  sys_ctrl_model u_sys_ctrl_model (.clk(clk), .enable_pin(enable_pin), .op_on(op_on),
    .vout_cmd_strobe(vout_cmd_strobe), .clear_faults(clear_faults), .latch_cfg(latch_cfg));

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Inputs always move 1 ns after the edge, so sampling never races the drive.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // A half-on, half-off pattern of 8-cycle phases shows exactly 8 lit samples in 16.
  task automatic blink_chk(input string what, input int idx);
    int ones;
    ones = 0;
    repeat (16) begin
      step(1);
      if (lamps[idx] === 1'b1) ones++;
    end
    chk(what, 10'h008, 10'(ones));
  endtask : blink_chk

  // The restart delay is bounded, so the wait for output return is bounded as well.
  task automatic wait_on();
    int k;
    k = 0;
    while (main_on !== 1'b1 && k < 60) begin
      step(1);
      k++;
    end
    chk("main_on restart", 10'h001, 10'(main_on));
  endtask : wait_on

  // One shutdown cause held for two edges, then released.
  task automatic shut(input shut_t cause, input bit latch);
    fault_live = cause;
    step(2);
    fault_live = 3'h0;
    chk("fault_pin", 10'h001, 10'(fault_pin));
    chk("fault lamp", 10'h001, 10'(lamps.fault_lamp));
    chk("latched_off", 10'(latch), 10'(status.latched_off));
    if (!latch) chk("alert in retry", 10'h001, 10'(smbalert_n));
  endtask : shut

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {ext_overload, input_out_of_range, input_absent, back_biased, hot_insert} = 5'h00;
    {bus_v_match, power_limit, bus_iface_mode, service_req} = 4'h0;
    bus_v_below_40 = 1'b1;
    output_present = 1'b1;
    fault_live = 3'h0;
    info_alarm = 9'h000;
    fan_speed_a = 8'h64;
    fan_speed_b = 8'h64;
    addr_sensed = 7'h5A;
    step(5);
    reset_n = 1'b1;
    step(3);
    chk("power-up alert", 10'h000, 10'(smbalert_n));
    chk("default addr", 10'h050, 10'(bus_addr));
    step(30);
    chk("derived addr", 10'h05A, 10'(bus_addr));
    u_sys_ctrl_model.pulse(1'b1);
    step(4);
    chk("alert after clear", 10'h001, 10'(smbalert_n));
    u_sys_ctrl_model.turn_on();
    step(3);
    chk("direct turn-on", 10'h001, 10'(main_on));
    input_out_of_range = 1'b1;
    blink_chk("input lamp", 3);
    input_out_of_range = 1'b0;
    service_req = 1'b1;
    blink_chk("service lamp", 0);
    service_req = 1'b0;
    bus_iface_mode = 1'b1;
    info_alarm = 9'h001;
    blink_chk("warning lamp", 1);
    chk("info alarm", 10'h001, 10'(alarm));
    chk("info no shutdown", 10'h001, 10'(main_on));
    {info_alarm, bus_iface_mode} = 10'h000;
    fan_speed_a = 8'h46;
    step(3);
    chk("fan wear", 10'h001, 10'(alarm.fan_wear));
    {fan_speed_a, fan_speed_b} = 16'h645A;
    step(3);
    chk("fan wear sticky", 10'h001, 10'(alarm.fan_wear));
    u_sys_ctrl_model.pulse(1'b1);
    step(3);
    chk("alarm cleared", 10'h000, 10'(alarm));
    ext_overload = 1'b1;
    blink_chk("output lamp", 2);
    chk("ext flag", 10'h001, 10'(status.ext_fault));
    chk("ext fault_pin", 10'h000, 10'(fault_pin));
    chk("ext fault lamp", 10'h000, 10'(lamps.fault_lamp));
    ext_overload = 1'b0;
    power_limit = 1'b1;
    blink_chk("limit lamp", 2);
    power_limit = 1'b0;
    output_present = 1'b0;
    step(2);
    chk("no output lamp", 10'h000, 10'(lamps.output_good_lamp));
    output_present = 1'b1;
    info_alarm = 9'h002;
    step(2);
    info_alarm = 9'h000;
    for (int i = 0; i < 2; i++) begin
      shut(i == 0 ? 3'h1 : 3'h2, 1'b0);
      wait_on();
      chk("restart_ok", 10'h001, 10'(status.restart_ok));
      chk("alarm on restart", 10'h000, 10'(alarm));
    end
    chk("sticky faults", 10'h003, 10'(status.fault));
    step(3);
    chk("alert after restart", 10'h000, 10'(smbalert_n));
    u_sys_ctrl_model.pulse(1'b1);
    step(4);
    chk("faults cleared", 10'h000, 10'(status.fault));
    for (int i = 0; i < 3; i++) begin
      u_sys_ctrl_model.set_latch(3'h1 << i);
      shut(3'h1 << i, 1'b1);
      step(30);
      chk("stays latched", 10'h000, 10'(main_on));
      u_sys_ctrl_model.set_latch(3'h0);
      u_sys_ctrl_model.turn_off();
      u_sys_ctrl_model.turn_on();
      step(3);
      chk("on after cycle", 10'h001, 10'(main_on));
    end
    for (int k = 0; k < 4; k++) begin
      shut(3'h4, k == 3);
      if (k < 3) wait_on();
    end
    u_sys_ctrl_model.turn_off();
    u_sys_ctrl_model.turn_on();
    step(3);
    shut(3'h4, 1'b0);
    wait_on();
    step(170);
    for (int k = 0; k < 3; k++) begin
      shut(3'h4, 1'b0);
      wait_on();
    end
    u_sys_ctrl_model.turn_off();
    bus_v_below_40 = 1'b0;
    u_sys_ctrl_model.turn_on();
    step(3);
    chk("mismatch off", 10'h000, 10'(main_on));
    chk("waiting_cmd", 10'h001, 10'(status.waiting_cmd));
    u_sys_ctrl_model.pulse(1'b0);
    step(3);
    chk("on after command", 10'h001, 10'(main_on));
    u_sys_ctrl_model.turn_off();
    bus_v_match = 1'b1;
    u_sys_ctrl_model.turn_on();
    step(3);
    chk("match turn-on", 10'h001, 10'(main_on));
    u_sys_ctrl_model.pulse(1'b1);
    addr_sensed = 7'h2C;
    hot_insert = 1'b1;
    step(1);
    hot_insert = 1'b0;
    step(3);
    chk("insert addr", 10'h020, 10'(bus_addr));
    chk("insert alert", 10'h000, 10'(smbalert_n));
    u_sys_ctrl_model.settle();
    chk("insert derived", 10'h02C, 10'(bus_addr));
    input_absent = 1'b1;
    step(3);
    chk("absent lamp", 10'h000, 10'(lamps.input_good_lamp));
    chk("absent off", 10'h000, 10'(main_on));
    // A second reset while held up through the rails must not announce power-up.
    back_biased = 1'b1;
    reset_n = 1'b0;
    step(3);
    reset_n = 1'b1;
    step(3);
    chk("back-biased alert", 10'h001, 10'(smbalert_n));
    chk("reset addr", 10'h020, 10'(bus_addr));
    print_verdict();
  end
endmodule : fault_restart_supervisor_test

/* File: verification/sys_ctrl_model.sv */
// Behavioural system controller that faces the supervisor on the management side.
// Assumes the bench calls its tasks; every signal moves 1 ns after a rising clock edge.
`timescale 1ns/1ps
module sys_ctrl_model #(
  parameter int unsigned OFF_HOLD_CYC = 24,
  parameter int unsigned SETTLE_CYC = 24
) (
  input wire logic clk, // System clock.
  output logic enable_pin, // Remote on/off drive.
  output logic op_on, // Operation command level.
  output logic vout_cmd_strobe, // Output voltage command pulse.
  output logic clear_faults, // Clear-faults command pulse.
  output frs_pkg::shut_t latch_cfg // Fault response selection.
);
  import frs_pkg::*;

  // The controller starts with the unit off and every cause on auto restart.
  initial begin
    enable_pin = 1'b0;
    op_on = 1'b0;
    vout_cmd_strobe = 1'b0;
    clear_faults = 1'b0;
    latch_cfg = 3'h0;
  end

  // Both on/off paths go high together.
  task automatic turn_on();
    @(posedge clk);
    #1;
    enable_pin = 1'b1;
    op_on = 1'b1;
  endtask : turn_on

  // hold off long
  // Off is held a full scaled hold, so a latch clears and the bias rails settle.
  task automatic turn_off();
    @(posedge clk);
    #1;
    enable_pin = 1'b0;
    op_on = 1'b0;
    repeat (OFF_HOLD_CYC) @(posedge clk);
    #1;
  endtask : turn_off

  // One-cycle strobe: 0 commands a voltage, 1 clears faults.
  task automatic pulse(input bit clr);
    @(posedge clk);
    #1;
    if (clr) clear_faults = 1'b1;
    else vout_cmd_strobe = 1'b1;
    @(posedge clk);
    #1;
    clear_faults = 1'b0;
    vout_cmd_strobe = 1'b0;
  endtask : pulse

  // Fault response changes take effect at the next edge.
  task automatic set_latch(input shut_t cfg);
    @(posedge clk);
    #1;
    latch_cfg = cfg;
  endtask : set_latch

  // settle after insertion
  // Bus traffic waits out the address settling time after presence is seen.
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge clk);
    #1;
  endtask : settle
endmodule : sys_ctrl_model
